// ==== hdl/host_config_pkg.sv ====
package host_config_pkg;

   // ***********************************************************
   // Address map
   // ***********************************************************
   localparam logic [6:0] page_sel_addr      = 7'h7f;
   localparam logic [7:0] last_direct_page   = 8'h09;
   localparam logic [7:0] gpio_page          = 8'h01;
   localparam logic [7:0] general_page       = 8'h00;
   localparam logic [7:0] output_mb_page     = 8'h0e;
   localparam logic [6:0] info_addr          = 7'h00;
   localparam logic [6:0] id_hi_addr         = 7'h01;
   localparam logic [6:0] id_lo_addr         = 7'h02;
   localparam logic [6:0] startup_hi_addr    = 7'h19;
   localparam logic [6:0] startup_lo_addr    = 7'h1a;
   localparam logic [6:0] clk_status_addr    = 7'h32;
   localparam logic [6:0] cfg_ready_addr     = 7'h33;
   localparam logic [6:0] out_enable_addr    = 7'h40;
   localparam logic [6:0] gpio_sel_base      = 7'h60;
   localparam logic [6:0] gpio_cfg_base      = 7'h62;
   localparam logic [6:0] gpio_out_addr      = 7'h6f;
   localparam logic [6:0] gpio_in_addr       = 7'h70;
   localparam logic [6:0] mb_mask_addr       = 7'h00;
   localparam logic [6:0] mb_sem_addr        = 7'h01;
   localparam logic [6:0] mb_data_base       = 7'h02;

   // ***********************************************************
   // Fields and reset values
   // ***********************************************************
   localparam int info_ready_bit   = 7;
   localparam int lock_bit         = 3;
   localparam int sem_fetch_bit    = 0;
   localparam int sem_commit_bit   = 1;
   localparam logic [7:0] info_booting = 8'h21;
   localparam logic [7:0] lock_status  = 8'h0b;
   localparam logic [7:0] zero_byte    = 8'h00;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int clk_mhz          = 50;
   localparam int strap_hold_ms    = 550;
   localparam int gpio_period_ms   = 10;
   localparam int strap_cycles     = strap_hold_ms * 1000 * clk_mhz;
   localparam int gpio_cycles      = gpio_period_ms * 1000 * clk_mhz;

   typedef enum logic [1:0] {
      gpio_in_e  = 2'h0,
      gpio_out_e = 2'h1,
      gpio_ctl_e = 2'h2,
      gpio_sts_e = 2'h3
   } gpio_mode_e;

   typedef enum logic [3:0] {
      st_cmd  = 4'h1,
      st_addr = 4'h2,
      st_wdat = 4'h4,
      st_rdat = 4'h8
   } spi_state_e;

   // Decoded SPI byte write as seen by the register file
   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } reg_write_s;

endpackage

// ==== hdl/host_config_port.sv ====
`timescale 1ns/1ps
module host_config_port
   import host_config_pkg::*;
#(
   parameter int          n_gpio       = 5,
   parameter int          n_outputs    = 10,
   parameter int          mb_bytes     = 8,
   parameter int          strap_count  = strap_cycles,
   parameter int          gpio_count   = gpio_cycles,
   parameter int          boot_count   = 1000,
   parameter logic [15:0] device_id    = 16'h0a5c,
   parameter logic        config_stored = 1'b0
)
(
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 spi_sck,
   input  wire logic                 select_strap_zero,
   input  wire logic                 spi_sdi,
   input  wire logic                 serial_out_strap_one,
   output logic                      spi_sdo,
   output logic                      spi_sdo_oe,
   input  wire logic [n_gpio-1:0]    gpio_in,
   output logic      [n_gpio-1:0]    gpio_out,
   output logic      [n_gpio-1:0]    gpio_oe,
   input  wire logic                 apll_locked,
   output logic      [n_outputs-1:0] out_enable,
   output logic                      spi_mode,
   output logic                      i2c_addr_lsb,
   output logic      [2:0]           config_choice,
   output logic                      straps_done,
   output logic      [n_outputs-1:0] mb_target,
   output logic      [mb_bytes*8-1:0] mb_commit_data,
   output logic                      mb_commit
);
   // ***********************************************************
   // Checks
   // ***********************************************************
   if (n_gpio < 3 || n_gpio > 8 || n_outputs > 16 || mb_bytes > 8)
      $error("host_config_port: unsupported parameters");

   // ***********************************************************
   // Synchronisers
   // ***********************************************************
   localparam int sw = 4 + n_gpio;
   logic [sw-1:0] sync_w;
   logic          sck_s, cs_s, sdi_s, so_s;
   logic [n_gpio-1:0] gpio_s;

   pin_sync #(.width(sw)) u_sync
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .async_in ({gpio_in, serial_out_strap_one, spi_sdi,
                  select_strap_zero, spi_sck}),
      .sync_out (sync_w)
   );
   assign sck_s  = sync_w[0];
   assign cs_s   = sync_w[1];
   assign sdi_s  = sync_w[2];
   assign so_s   = sync_w[3];
   assign gpio_s = sync_w[sw-1:4];

   // ***********************************************************
   // Strap sampling and boot
   // ***********************************************************
   logic [31:0] strap_cnt_reg;
   logic [15:0] boot_cnt_reg;
   logic        ready_reg;
   logic [15:0] startup_reg;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         strap_cnt_reg <= '0;
         straps_done   <= 1'b0;
         spi_mode      <= 1'b0;
         i2c_addr_lsb  <= 1'b0;
         config_choice <= 3'h0;
         startup_reg   <= 16'h0000;
      end
      else if (!straps_done)
      begin
         strap_cnt_reg <= strap_cnt_reg + 32'd1;
         if (strap_cnt_reg == 32'(strap_count - 1))
         begin
            straps_done   <= 1'b1;
            spi_mode      <= cs_s;
            i2c_addr_lsb  <= so_s;
            startup_reg   <= 16'(gpio_s);
            config_choice <= config_stored ? gpio_s[2:0] : 3'h0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         boot_cnt_reg <= '0;
         ready_reg    <= 1'b0;
      end
      else if (straps_done && !ready_reg)
      begin
         boot_cnt_reg <= boot_cnt_reg + 16'd1;
         if (boot_cnt_reg == 16'(boot_count - 1))
            ready_reg <= 1'b1;
      end
   end

   // ***********************************************************
   // SPI target
   // ***********************************************************
   spi_state_e  state_reg;
   logic        sck_d_reg, cs_d_reg, lsb_first_reg;
   logic [7:0]  shift_reg, tx_reg;
   logic [2:0]  bit_cnt_reg;
   logic        rd_reg;
   logic [6:0]  addr_reg;
   reg_write_s  wr_pulse_reg;
   logic [7:0]  rd_data;

   wire active    = spi_mode && straps_done && !cs_s;
   wire cs_fall   = cs_d_reg && !cs_s;
   wire sck_rise  = !sck_d_reg && sck_s;
   wire sck_fall  = sck_d_reg && !sck_s;
   wire in_bit    = sdi_s;
   wire [7:0] byte_in = lsb_first_reg ? {in_bit, shift_reg[7:1]}
                                      : {shift_reg[6:0], in_bit};
   wire last_bit  = bit_cnt_reg == 3'h7;
   wire [7:0] rd_view = ready_reg ? rd_data : zero_byte;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sck_d_reg     <= 1'b0;
         cs_d_reg      <= 1'b0;
         lsb_first_reg <= 1'b0;
         state_reg     <= st_cmd;
         shift_reg     <= 8'h00;
         bit_cnt_reg   <= 3'h0;
         rd_reg        <= 1'b0;
         addr_reg      <= 7'h00;
         wr_pulse_reg  <= '0;
         tx_reg        <= 8'h00;
         spi_sdo       <= 1'b0;
         spi_sdo_oe    <= 1'b0;
      end
      else
      begin
         sck_d_reg        <= sck_s;
         cs_d_reg         <= cs_s;
         wr_pulse_reg.wr  <= 1'b0;
         if (cs_fall)
            lsb_first_reg <= sck_s;
         if (!active)
         begin
            state_reg   <= st_cmd;
            bit_cnt_reg <= 3'h0;
            spi_sdo_oe  <= 1'b0;
         end
         else if (sck_rise)
         begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg   <= byte_in;
            if (last_bit)
            begin
               case (state_reg)
                  st_cmd, st_addr:
                  begin
                     rd_reg   <= lsb_first_reg ? byte_in[0] : byte_in[7];
                     addr_reg <= lsb_first_reg ? byte_in[7:1] : byte_in[6:0];
                     if (lsb_first_reg ? byte_in[0] : byte_in[7])
                     begin
                        state_reg  <= st_rdat;
                        spi_sdo_oe <= 1'b1;
                        tx_reg     <= 8'h00;
                     end
                     else
                        state_reg <= st_wdat;
                  end
                  st_wdat:
                  begin
                     wr_pulse_reg.wr   <= 1'b1;
                     wr_pulse_reg.addr <= addr_reg;
                     wr_pulse_reg.data <= byte_in;
                     addr_reg <= addr_reg + 7'h01;
                  end
                  st_rdat:
                     addr_reg <= addr_reg + 7'h01;
                  default:
                     state_reg <= st_cmd;
               endcase
            end
            // Input is ignored during read-out
            if (state_reg == st_rdat)
               shift_reg <= shift_reg;
         end
         else if (sck_fall && state_reg == st_rdat)
         begin
            // Load a fresh byte at each byte boundary, else shift
            if (bit_cnt_reg == 3'h0)
            begin
               tx_reg  <= lsb_first_reg ? {1'b0, rd_view[7:1]}
                                        : {rd_view[6:0], 1'b0};
               spi_sdo <= lsb_first_reg ? rd_view[0] : rd_view[7];
            end
            else
            begin
               tx_reg  <= lsb_first_reg ? {1'b0, tx_reg[7:1]}
                                        : {tx_reg[6:0], 1'b0};
               spi_sdo <= lsb_first_reg ? tx_reg[0] : tx_reg[7];
            end
         end
      end
   end

   // ***********************************************************
   // Register file
   // ***********************************************************
   logic [7:0]  page_reg, cfg_ready_reg, gpio_drive_reg, gpio_rb_reg;
   logic [15:0] gsel_reg [n_gpio];
   logic [1:0]  gmode_reg [n_gpio];
   logic [7:0]  id_hold_reg, gsel_hold_reg;
   logic [15:0] oen_reg;
   logic [7:0]  mbox_reg [mb_bytes];
   logic [n_outputs-1:0] inst_reg [0:0];

   wire is_mb   = page_reg > last_direct_page;
   wire mb_ok   = ready_reg && apll_locked;
   wire [7:0] info_v = ready_reg ? (info_booting | 8'h80) : info_booting;
   wire [7:0] status_v = {4'h0, apll_locked, 1'b0, ready_reg, ready_reg};
   wire [6:0] wa = wr_pulse_reg.addr;
   wire [7:0] wd = wr_pulse_reg.data;
   wire       we = wr_pulse_reg.wr;

   assign rd_data =
      (addr_reg == page_sel_addr) ? page_reg :
      is_mb ? ((page_reg == output_mb_page && addr_reg == mb_mask_addr) ?
               8'(mb_target) :
               (page_reg == output_mb_page && addr_reg >= mb_data_base &&
                addr_reg < mb_data_base + 7'(mb_bytes)) ?
               mbox_reg[3'(addr_reg - mb_data_base)] : zero_byte) :
      (page_reg == general_page && addr_reg == info_addr) ? info_v :
      (page_reg == general_page && addr_reg == id_hi_addr) ?
         device_id[15:8] :
      (page_reg == general_page && addr_reg == id_lo_addr) ?
         device_id[7:0] :
      (page_reg == general_page && addr_reg == startup_hi_addr) ?
         startup_reg[15:8] :
      (page_reg == general_page && addr_reg == startup_lo_addr) ?
         startup_reg[7:0] :
      (page_reg == general_page && addr_reg == clk_status_addr) ? status_v :
      (page_reg == general_page && addr_reg == cfg_ready_addr) ?
         cfg_ready_reg :
      (page_reg == gpio_page && addr_reg == gpio_out_addr) ? gpio_drive_reg :
      (page_reg == gpio_page && addr_reg == gpio_in_addr) ? gpio_rb_reg :
      zero_byte;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         page_reg       <= 8'h00;
         cfg_ready_reg  <= 8'h00;
         gpio_drive_reg <= 8'h00;
         oen_reg        <= 16'h0000;
         gsel_hold_reg  <= 8'h00;
         id_hold_reg    <= 8'h00;
         mb_target      <= '0;
         mb_commit      <= 1'b0;
         mb_commit_data <= '0;
         for (int i = 0; i < n_gpio; i++)
         begin
            gsel_reg[i]  <= 16'h0000;
            gmode_reg[i] <= 2'h0;
         end
         for (int i = 0; i < mb_bytes; i++)
            mbox_reg[i] <= 8'h00;
      end
      else
      begin
         mb_commit <= 1'b0;
         if (we && wa == page_sel_addr)
            page_reg <= wd;
         else if (we && is_mb && mb_ok && page_reg == output_mb_page)
         begin
            if (wa == mb_mask_addr)
               mb_target <= n_outputs'(wd);
            else if (wa == mb_sem_addr && wd[sem_commit_bit])
            begin
               mb_commit <= 1'b1;
               for (int i = 0; i < mb_bytes; i++)
                  mb_commit_data[i*8 +: 8] <= mbox_reg[i];
            end
            else if (wa == mb_sem_addr && wd[sem_fetch_bit])
            begin
               for (int i = 0; i < mb_bytes; i++)
                  mbox_reg[i] <= mb_commit_data[i*8 +: 8];
            end
            else if (wa >= mb_data_base && wa < mb_data_base + 7'(mb_bytes))
               mbox_reg[3'(wa - mb_data_base)] <= wd;
         end
         else if (we && page_reg == general_page)
         begin
            if (wa == cfg_ready_addr)
               cfg_ready_reg <= wd;
            else if (wa == out_enable_addr)
               id_hold_reg <= wd;
            else if (wa == out_enable_addr + 7'h01)
               oen_reg <= {id_hold_reg, wd};
         end
         else if (we && page_reg == gpio_page)
         begin
            if (wa == gpio_out_addr)
               gpio_drive_reg <= wd;
            for (int i = 0; i < n_gpio; i++)
            begin
               if (wa == gpio_sel_base + 7'(3*i))
                  gsel_hold_reg <= wd;
               else if (wa == gpio_sel_base + 7'(3*i+1))
                  gsel_reg[i] <= {gsel_hold_reg, wd};
               else if (wa == gpio_cfg_base + 7'(3*i))
                  gmode_reg[i] <= wd[1:0];
            end
         end
      end
   end

   // ***********************************************************
   // GPIO periodic update
   // ***********************************************************
   // Slow refresh keeps pin activity off the clock paths
   logic [31:0] gtick_reg;
   wire gtick = gtick_reg == 32'(gpio_count - 1);
   logic [15:0] ctl_reg;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         gtick_reg   <= '0;
         gpio_out    <= '0;
         gpio_oe     <= '0;
         gpio_rb_reg <= 8'h00;
         ctl_reg     <= 16'h0000;
         out_enable  <= '0;
      end
      else
      begin
         gtick_reg  <= gtick ? 32'd0 : gtick_reg + 32'd1;
         out_enable <= n_outputs'(oen_reg | ctl_reg);
         if (gtick)
         begin
            gpio_rb_reg <= 8'(gpio_s);
            for (int i = 0; i < n_gpio; i++)
            begin
               gpio_oe[i] <= gmode_reg[i] == gpio_out_e ||
                             gmode_reg[i] == gpio_sts_e;
               if (gmode_reg[i] == gpio_out_e)
                  gpio_out[i] <= gpio_drive_reg[i];
               else if (gmode_reg[i] == gpio_sts_e)
                  gpio_out[i] <= status_v[gsel_reg[i][2:0]];
               if (gmode_reg[i] == gpio_ctl_e)
                  ctl_reg[gsel_reg[i][3:0]] <= gpio_s[i];
            end
         end
      end
   end
endmodule

// ==== hdl/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync
#(
   parameter int width = 1
)
(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [width-1:0] async_in,
   output logic      [width-1:0] sync_out
);
   logic [width-1:0] meta_reg;

   // First stage feeds only the second stage
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta_reg <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// ==== sim/host_config_port_assertions.sv ====
`timescale 1ns/1ps
module host_config_port_checker
#(
   parameter int   n_outputs     = 10,
   parameter int   strap_count   = 20,
   parameter logic config_stored = 1'b0
)
(
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire logic                 select_strap_zero,
   input wire logic                 spi_sdo_oe,
   input wire logic                 apll_locked,
   input wire logic [n_outputs-1:0] out_enable,
   input wire logic                 spi_mode,
   input wire logic                 i2c_addr_lsb,
   input wire logic [2:0]           config_choice,
   input wire logic                 straps_done,
   input wire logic                 mb_commit
);
   // ****************
   // Strap timing
   // ****************
   int wait_reg;
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         wait_reg <= 0;
      else if (!straps_done)
         wait_reg <= wait_reg + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence cs_idle;
      select_strap_zero [*8];
   endsequence
   sequence cs_release;
      $rose(select_strap_zero);
   endsequence
   // ****************
   // Checks
   // ****************
   AST_STRAP_TIME: assert property ($rose(straps_done) |->
      wait_reg >= strap_count - 2 && wait_reg <= strap_count + 4)
      else $error("strap sample time off");
   AST_STRAP_HOLD: assert property (straps_done |=> straps_done &&
      $stable(spi_mode) && $stable(i2c_addr_lsb))
      else $error("strap values moved");
   AST_OUTS_OFF: assert property (!straps_done |-> out_enable == '0)
      else $error("output enabled before setup");
   AST_CHOICE_IGNORED: assert property (straps_done && !config_stored
      |-> config_choice == 3'h0)
      else $error("config choice taken with nothing stored");
   AST_OE_RELEASE: assert property (cs_release |-> ##[1:6] !spi_sdo_oe)
      else $error("output driver kept after select rise");
   AST_OE_IDLE: assert property (cs_idle |-> !spi_sdo_oe)
      else $error("output driver on while deselected");
   AST_OE_START: assert property ($rose(spi_sdo_oe) |->
      !select_strap_zero && spi_mode)
      else $error("output driver on outside a frame");
   AST_COMMIT_LOCK: assert property (mb_commit |-> apll_locked)
      else $error("mailbox commit without lock");
   AST_COMMIT_PULSE: assert property (mb_commit |=> !mb_commit)
      else $error("commit pulse too long");
endmodule
bind host_config_port host_config_port_checker
#(
   .n_outputs     (n_outputs),
   .strap_count   (strap_count),
   .config_stored (config_stored)
)
host_config_port_checker_inst
(
   .clk               (clk),
   .sys_rst           (sys_rst),
   .select_strap_zero (select_strap_zero),
   .spi_sdo_oe        (spi_sdo_oe),
   .apll_locked       (apll_locked),
   .out_enable        (out_enable),
   .spi_mode          (spi_mode),
   .i2c_addr_lsb      (i2c_addr_lsb),
   .config_choice     (config_choice),
   .straps_done       (straps_done),
   .mb_commit         (mb_commit)
);

// ==== sim/host_config_port_tb.sv ====
`timescale 1ns/1ps
module host_config_port_tb
   import host_config_pkg::*;
;
   // Identity value is arbitrary
   localparam logic [15:0] dev_id = 16'h3c96;
   logic        clk, sys_rst, sck, cs_n, sdi, so_line, strap_one;
   logic        spi_sdo, spi_sdo_oe, apll_locked, spi_mode, i2c_addr_lsb;
   logic        straps_done, mb_commit;
   logic [4:0]  gpio_in, gpio_out, gpio_oe;
   logic [9:0]  out_enable, mb_target;
   logic [2:0]  config_choice;
   logic [63:0] mb_commit_data;
   logic [7:0]  r;
   int          bad_count = 0;
   int          checks = 0;
   int          commits = 0;
   assign so_line = spi_sdo_oe ? spi_sdo : strap_one;
   host_config_port #(.strap_count(20), .gpio_count(16), .boot_count(200),
      .device_id(dev_id)) host_config_port_inst
   (
      .clk(clk), .sys_rst(sys_rst), .spi_sck(sck),
      .select_strap_zero(cs_n), .spi_sdi(sdi),
      .serial_out_strap_one(so_line), .spi_sdo(spi_sdo),
      .spi_sdo_oe(spi_sdo_oe), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .apll_locked(apll_locked), .out_enable(out_enable),
      .spi_mode(spi_mode), .i2c_addr_lsb(i2c_addr_lsb),
      .config_choice(config_choice), .straps_done(straps_done),
      .mb_target(mb_target), .mb_commit_data(mb_commit_data),
      .mb_commit(mb_commit)
   );
   spi_host_model spi_host_model_inst
   (
      .clk(clk), .so_line(so_line), .sck(sck), .cs_n(cs_n), .sdi(sdi)
   );
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
      if (mb_commit === 1'b1)
         commits++;
   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      spi_host_model_inst.start(1'b0, 1'b0, a);
      spi_host_model_inst.byte_io(d, r);
      spi_host_model_inst.stop();
   endtask
   task automatic rd(input logic lsb, input logic [6:0] a);
      spi_host_model_inst.start(lsb, 1'b1, a);
      spi_host_model_inst.byte_io(8'h5a, r);
      spi_host_model_inst.stop();
   endtask
   task automatic test_done();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************
   // Tests
   // ****************
   initial
   begin
      sys_rst = 1'b1;
      gpio_in = 5'h05;
      apll_locked = 1'b0;
      strap_one = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      for (int i = 0; i < 100 && straps_done !== 1'b1; i++)
         @(negedge clk);
      chk(spi_mode, 1'b1);
      chk(i2c_addr_lsb, 1'b1);
      chk(config_choice, 3'h0);
      chk(out_enable, 10'h000);
      rd(1'b0, id_hi_addr);
      chk(r, 8'h00);
      for (int i = 0; i < 4 && r !== dev_id[15:8]; i++)
         rd(1'b0, id_hi_addr);
      chk(r, dev_id[15:8]);
      rd(1'b1, id_lo_addr);
      chk(r, dev_id[7:0]);
      spi_host_model_inst.start(1'b0, 1'b0, out_enable_addr);
      spi_host_model_inst.byte_io(8'h02, r);
      chk(out_enable, 10'h000);
      spi_host_model_inst.byte_io(8'h81, r);
      spi_host_model_inst.stop();
      chk(out_enable, 10'h281);
      wr(page_sel_addr, gpio_page);
      rd(1'b0, page_sel_addr);
      chk(r, gpio_page);
      wr(gpio_cfg_base, 8'h01);
      wr(gpio_out_addr, 8'h01);
      wr(gpio_sel_base + 7'h0a, 8'h05);
      wr(gpio_cfg_base + 7'h09, 8'h02);
      wr(gpio_sel_base + 7'h04, 8'h03);
      wr(gpio_cfg_base + 7'h03, 8'h03);
      gpio_in = 5'h0d;
      repeat (40) @(negedge clk);
      chk({gpio_oe[0], gpio_out[0]}, 2'h3);
      chk(out_enable, 10'h2a1);
      chk({gpio_oe[1], gpio_out[1]}, 2'h2);
      rd(1'b0, gpio_in_addr);
      chk(r, 8'h0d);
      wr(page_sel_addr, output_mb_page);
      wr(mb_mask_addr, 8'h04);
      wr(mb_sem_addr, 8'h02);
      chk(commits, 0);
      chk(mb_target, 10'h000);
      apll_locked = 1'b1;
      wr(mb_mask_addr, 8'h04);
      wr(mb_data_base, 8'ha5);
      wr(mb_sem_addr, 8'h02);
      chk(commits, 1);
      chk(mb_target, 10'h004);
      chk(mb_commit_data[7:0], 8'ha5);
      chk(gpio_out[1], 1'b1);
      wr(mb_data_base, 8'h3c);
      wr(mb_sem_addr, 8'h01);
      rd(1'b0, mb_data_base);
      chk(r, 8'ha5);
      test_done();
   end
   initial
   begin
      repeat (10000) @(posedge clk);
      bad_count++;
      test_done();
   end
endmodule

// ==== sim/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model
(
   input  wire logic clk,
   input  wire logic so_line,
   output logic      sck,
   output logic      cs_n,
   output logic      sdi
);
   // ****************
   // Host controller
   // ****************
   logic lsb_mode = 1'b0;
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   task automatic half();
      repeat (4) @(negedge clk);
   endtask
   // Read data is taken late in the high phase, where it is settled
   task automatic bit_io(input logic b, output logic got);
      sck = 1'b0;
      sdi = b;
      half();
      sck = 1'b1;
      repeat (3) @(negedge clk);
      got = so_line;
      @(negedge clk);
   endtask
   task automatic start(input logic lsb, input logic rd, input logic [6:0] a);
      logic g;
      @(negedge clk);
      lsb_mode = lsb;
      sck = lsb;
      half();
      cs_n = 1'b0;
      half();
      bit_io(rd, g);
      for (int i = 0; i < 7; i++)
         bit_io(lsb ? a[i] : a[6-i], g);
   endtask
   task automatic byte_io(input logic [7:0] w, output logic [7:0] got);
      int k;
      for (int i = 0; i < 8; i++)
      begin
         k = lsb_mode ? i : 7 - i;
         bit_io(w[k], got[k]);
      end
   endtask
   // Clock stands still between frames
   task automatic stop();
      half();
      sck = lsb_mode;
      half();
      cs_n = 1'b1;
      sdi = ~sdi;
      half();
   endtask
endmodule
